// >>> hdl/board_ctrl_regs.sv
`timescale 1ns/1ps

// Overview of operation
// - low byte of vector register answers interrupt acknowledge; upper byte unused
// - vector register comes out of reset holding 0xdd
// - slot-position register is read-only, reflecting geographical pins
// - boards without geographical pins read slot-position as 0x1f
// - any write to module reset location gives one reset shot
// - revision reads major in upper byte, minor in lower byte
// - 16-bit scratch register, read and write
// - 32-bit scratch register, read and write
// - select and data register pair for each configuration flash
// - writing user-configuration register reloads the user logic image
// - image-choice bit at one selects the standard image
// - user logic gets one active-low asynchronous reset line
// - user logic gets a 40 MHz local bus clock
// - separate active-high write and read strobes announce local accesses
// - local port: 16-bit address, write data out, read data in
// - qualifier high while access falls in user address space
// - each strobe lasts one local clock; only valid with qualifier
// - write data stable on the local edge where strobe is active
// - module reset write pulses the local reset line low
module board_ctrl_regs
  import board_ctrl_pkg::*;
#(
  parameter bit HAS_GEO_PINS = 1'b1,
  parameter logic [7:0] FW_MAJOR = 8'h01,
  parameter logic [7:0] FW_MINOR = 8'h02
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [15:0] busAddr,
  input wire logic [31:0] busWriteData,
  input wire logic busWrite,
  input wire logic busRead,
  input wire logic iackCycle,
  output logic [31:0] busReadData,
  output logic busAck,
  output logic busBusy,
  input wire logic [4:0] geoPins,
  output logic [1:0][15:0] flashSelect,
  output logic [15:0] flashWriteData,
  output logic [1:0] flashWriteStrobe,
  output logic [1:0] flashReadStrobe,
  input wire logic [1:0][15:0] flashReadData,
  output logic userConfigReload,
  output logic userImageStandard,
  output logic localBusClock,
  output logic localBusReset_n,
  output logic localWriteStrobe,
  output logic localReadStrobe,
  output logic [15:0] localAddr,
  output logic [15:0] localWriteData,
  input wire logic [15:0] localReadData,
  output logic userSpaceHit
);

  ////////////////////////////////////////////////////////////////////////
  // local clock source
  logic localClk;
  logic toggleNow;
  logic localFall;
  logic localRise;

  local_clock_gen #(
    .SYS_MHZ(SYS_CLK_MHZ),
    .LOC_MHZ(LOCAL_CLK_MHZ)
  ) u_clock (
    .sys_clk(sys_clk),
    .rst(rst),
    .localClk(localClk),
    .toggleNow(toggleNow)
  );

  assign localFall = toggleNow && localClk;
  assign localRise = toggleNow && !localClk;

  ////////////////////////////////////////////////////////////////////////
  // request decode
  logic accept;
  logic doWrite;
  logic doRead;
  logic userHit;
  logic moduleResetHit;
  logic [15:0] slotValue;
  logic [15:0] fwValue;

  assign accept = !busBusy && (busWrite || busRead || iackCycle);
  assign doWrite = !busBusy && busWrite && !iackCycle;
  assign doRead = !busBusy && busRead && !busWrite && !iackCycle;
  assign userHit = busAddr < USER_SPACE_LIMIT;
  assign moduleResetHit = doWrite && (busAddr == OFS_MODULE_RESET);
  // live pin levels or fixed value
  assign slotValue = HAS_GEO_PINS ? {11'h000, geoPins}
                                  : {11'h000, SLOT_NO_GEO};
  assign fwValue = {FW_MAJOR, FW_MINOR};

  ////////////////////////////////////////////////////////////////////////
  // software registers
  logic [7:0] irqVector_reg;
  logic [7:0] irqVector_next;
  logic [15:0] scratchShort_reg;
  logic [15:0] scratchShort_next;
  logic [31:0] scratchLong_reg;
  logic [31:0] scratchLong_next;
  logic [1:0][15:0] flashSelect_reg;
  logic [1:0][15:0] flashSelect_next;
  logic [15:0] userConfig_reg;
  logic [15:0] userConfig_next;
  logic [15:0] flashWriteData_reg;
  logic [15:0] flashWriteData_next;
  logic [1:0] flashWriteStrobe_reg;
  logic [1:0] flashWriteStrobe_next;
  logic [1:0] flashReadStrobe_reg;
  logic [1:0] flashReadStrobe_next;
  logic reload_reg;
  logic reload_next;

  always_comb begin
    irqVector_next = irqVector_reg;
    scratchShort_next = scratchShort_reg;
    scratchLong_next = scratchLong_reg;
    flashSelect_next = flashSelect_reg;
    userConfig_next = userConfig_reg;
    flashWriteData_next = flashWriteData_reg;
    flashWriteStrobe_next = 2'b00;
    flashReadStrobe_next = 2'b00;
    reload_next = 1'b0;
    if (moduleResetHit) begin
      irqVector_next = IRQ_VECTOR_RESET;
      scratchShort_next = 16'h0000;
      scratchLong_next = 32'h0000_0000;
      flashSelect_next = '0;
      userConfig_next = 16'h0000;
    end else if (doWrite) begin
      if (busAddr == OFS_IRQ_VECTOR) begin
        irqVector_next = busWriteData[7:0];
      end else if (busAddr == OFS_SCRATCH_SHORT) begin
        scratchShort_next = busWriteData[15:0];
      end else if (busAddr == OFS_SCRATCH_LONG) begin
        scratchLong_next = busWriteData;
      end else if (busAddr == OFS_BRIDGE_FLASH_SEL) begin
        flashSelect_next[FLASH_BRIDGE] = busWriteData[15:0];
      end else if (busAddr == OFS_USER_FLASH_SEL) begin
        flashSelect_next[FLASH_USER] = busWriteData[15:0];
      end else if (busAddr == OFS_BRIDGE_FLASH_DATA) begin
        flashWriteData_next = busWriteData[15:0];
        flashWriteStrobe_next[FLASH_BRIDGE] = 1'b1;
      end else if (busAddr == OFS_USER_FLASH_DATA) begin
        flashWriteData_next = busWriteData[15:0];
        flashWriteStrobe_next[FLASH_USER] = 1'b1;
      end else if (busAddr == OFS_USER_CONFIG) begin
        userConfig_next = busWriteData[15:0];
        reload_next = 1'b1;
      end
    end else if (doRead) begin
      if (busAddr == OFS_BRIDGE_FLASH_DATA) begin
        flashReadStrobe_next[FLASH_BRIDGE] = 1'b1;
      end else if (busAddr == OFS_USER_FLASH_DATA) begin
        flashReadStrobe_next[FLASH_USER] = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irqVector_reg <= IRQ_VECTOR_RESET;
      scratchShort_reg <= 16'h0000;
      scratchLong_reg <= 32'h0000_0000;
      flashSelect_reg <= '0;
      userConfig_reg <= 16'h0000;
      flashWriteData_reg <= 16'h0000;
      flashWriteStrobe_reg <= 2'b00;
      flashReadStrobe_reg <= 2'b00;
      reload_reg <= 1'b0;
    end else begin
      irqVector_reg <= irqVector_next;
      scratchShort_reg <= scratchShort_next;
      scratchLong_reg <= scratchLong_next;
      flashSelect_reg <= flashSelect_next;
      userConfig_reg <= userConfig_next;
      flashWriteData_reg <= flashWriteData_next;
      flashWriteStrobe_reg <= flashWriteStrobe_next;
      flashReadStrobe_reg <= flashReadStrobe_next;
      reload_reg <= reload_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // module reset pulse toward user logic
  logic [7:0] resetCount_reg;
  logic [7:0] resetCount_next;
  logic localReset_n_reg;
  logic localReset_n_next;

  always_comb begin
    resetCount_next = resetCount_reg;
    if (moduleResetHit) begin
      resetCount_next = 8'(RESET_PULSE_CYCLES);
    end else if (resetCount_reg != 8'h00) begin
      resetCount_next = resetCount_reg - 8'h01;
    end
    localReset_n_next = (resetCount_next == 8'h00);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      resetCount_reg <= 8'h00;
      localReset_n_reg <= 1'b0;
    end else begin
      resetCount_reg <= resetCount_next;
      localReset_n_reg <= localReset_n_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // local register port sequencer and bus answer
  local_state_t state_reg;
  local_state_t state_next;
  logic [15:0] localAddr_reg;
  logic [15:0] localAddr_next;
  logic [15:0] localData_reg;
  logic [15:0] localData_next;
  logic localDir_reg;
  logic localDir_next;
  logic wrStrobe_reg;
  logic wrStrobe_next;
  logic rdStrobe_reg;
  logic rdStrobe_next;
  logic hit_reg;
  logic hit_next;
  logic [15:0] captured_reg;
  logic [15:0] captured_next;
  logic [31:0] readData_reg;
  logic [31:0] readData_next;
  logic ack_reg;
  logic ack_next;
  logic busBusy_reg;
  logic busBusy_next;

  always_comb begin
    state_next = state_reg;
    localAddr_next = localAddr_reg;
    localData_next = localData_reg;
    localDir_next = localDir_reg;
    wrStrobe_next = wrStrobe_reg;
    rdStrobe_next = rdStrobe_reg;
    hit_next = hit_reg;
    captured_next = captured_reg;
    readData_next = readData_reg;
    ack_next = 1'b0;
    busBusy_next = busBusy_reg;
    case (state_reg)
      LS_IDLE: begin
        if (accept && iackCycle) begin
          readData_next = {24'h000000, irqVector_reg};
          ack_next = 1'b1;
        end else if (accept && userHit) begin
          // latch address and data, raise qualifier
          localAddr_next = busAddr;
          localData_next = busWriteData[15:0];
          localDir_next = doWrite;
          hit_next = 1'b1;
          busBusy_next = 1'b1;
          state_next = LS_WAIT;
        end else if (accept) begin
          ack_next = 1'b1;
          readData_next = 32'h0000_0000;
          if (doRead) begin
            if (busAddr == OFS_IRQ_VECTOR) begin
              readData_next = {24'h000000, irqVector_reg};
            end else if (busAddr == OFS_SLOT_POSITION) begin
              readData_next = {16'h0000, slotValue};
            end else if (busAddr == OFS_FW_REVISION) begin
              readData_next = {16'h0000, fwValue};
            end else if (busAddr == OFS_BRIDGE_FLASH_SEL) begin
              readData_next = {16'h0000, flashSelect_reg[FLASH_BRIDGE]};
            end else if (busAddr == OFS_USER_FLASH_SEL) begin
              readData_next = {16'h0000, flashSelect_reg[FLASH_USER]};
            end else if (busAddr == OFS_BRIDGE_FLASH_DATA) begin
              readData_next = {16'h0000, flashReadData[FLASH_BRIDGE]};
            end else if (busAddr == OFS_USER_FLASH_DATA) begin
              readData_next = {16'h0000, flashReadData[FLASH_USER]};
            end else if (busAddr == OFS_USER_CONFIG) begin
              readData_next = {16'h0000, userConfig_reg};
            end else if (busAddr == OFS_SCRATCH_SHORT) begin
              readData_next = {16'h0000, scratchShort_reg};
            end else if (busAddr == OFS_SCRATCH_LONG) begin
              readData_next = scratchLong_reg;
            end
          end
        end
      end
      LS_WAIT: begin
        // strobe starts at a falling local edge
        if (localFall) begin
          wrStrobe_next = localDir_reg;
          rdStrobe_next = !localDir_reg;
          state_next = LS_STROBE;
        end
      end
      LS_STROBE: begin
        // read data sampled at the rising local edge
        if (localRise && rdStrobe_reg) begin
          captured_next = localReadData;
        end
        // strobe ends one local period later
        if (localFall) begin
          wrStrobe_next = 1'b0;
          rdStrobe_next = 1'b0;
          state_next = LS_FINISH;
        end
      end
      LS_FINISH: begin
        hit_next = 1'b0;
        busBusy_next = 1'b0;
        ack_next = 1'b1;
        readData_next = localDir_reg ? 32'h0000_0000
                                     : {16'h0000, captured_reg};
        state_next = LS_IDLE;
      end
      default: begin
        state_next = LS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= LS_IDLE;
      localAddr_reg <= 16'h0000;
      localData_reg <= 16'h0000;
      localDir_reg <= 1'b0;
      wrStrobe_reg <= 1'b0;
      rdStrobe_reg <= 1'b0;
      hit_reg <= 1'b0;
      captured_reg <= 16'h0000;
      readData_reg <= 32'h0000_0000;
      ack_reg <= 1'b0;
      busBusy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      localAddr_reg <= localAddr_next;
      localData_reg <= localData_next;
      localDir_reg <= localDir_next;
      wrStrobe_reg <= wrStrobe_next;
      rdStrobe_reg <= rdStrobe_next;
      hit_reg <= hit_next;
      captured_reg <= captured_next;
      readData_reg <= readData_next;
      ack_reg <= ack_next;
      busBusy_reg <= busBusy_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign busReadData = readData_reg;
  assign busAck = ack_reg;
  assign busBusy = busBusy_reg;
  assign flashSelect = flashSelect_reg;
  assign flashWriteData = flashWriteData_reg;
  assign flashWriteStrobe = flashWriteStrobe_reg;
  assign flashReadStrobe = flashReadStrobe_reg;
  assign userConfigReload = reload_reg;
  assign userImageStandard = userConfig_reg[IMAGE_SELECT_BIT];
  assign localBusClock = localClk;
  assign localBusReset_n = localReset_n_reg;
  assign localWriteStrobe = wrStrobe_reg;
  assign localReadStrobe = rdStrobe_reg;
  assign localAddr = localAddr_reg;
  assign localWriteData = localData_reg;
  assign userSpaceHit = hit_reg;

  ////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic anyStrobe;
  assign anyStrobe = wrStrobe_reg || rdStrobe_reg;

  property p_iack_vector;
    iackCycle && !busBusy |=> busAck && busReadData[7:0] ==
      $past(irqVector_reg) && busReadData[31:8] == 24'h000000;
  endproperty
  a_iack_vector: assert property (p_iack_vector)
    else $error("vector not returned on acknowledge");

  property p_slot_read;
    busRead && !busWrite && !iackCycle && !busBusy &&
      busAddr == OFS_SLOT_POSITION |=> busReadData == {16'h0000,
      $past(slotValue)};
  endproperty
  a_slot_read: assert property (p_slot_read)
    else $error("slot position readback wrong");

  property p_reset_pulse;
    moduleResetHit |=> !localBusReset_n [*8];
  endproperty
  a_reset_pulse: assert property (p_reset_pulse)
    else $error("local reset pulse missing");

  property p_scratch_short;
    doWrite && busAddr == OFS_SCRATCH_SHORT |=>
      scratchShort_reg == $past(busWriteData[15:0]);
  endproperty
  a_scratch_short: assert property (p_scratch_short)
    else $error("short scratch not written");

  property p_scratch_long;
    doWrite && busAddr == OFS_SCRATCH_LONG |=>
      scratchLong_reg == $past(busWriteData);
  endproperty
  a_scratch_long: assert property (p_scratch_long)
    else $error("long scratch not written");

  property p_reload;
    doWrite && busAddr == OFS_USER_CONFIG ##1 !doWrite |->
      userConfigReload ##1
      !userConfigReload && userImageStandard == $past(busWriteData[0], 2);
  endproperty
  a_reload: assert property (p_reload)
    else $error("configuration reload not issued");

  property p_strobe_qualified;
    anyStrobe |-> userSpaceHit && !(wrStrobe_reg && rdStrobe_reg);
  endproperty
  a_strobe_qualified: assert property (p_strobe_qualified)
    else $error("strobe outside user space");

  property p_strobe_length;
    $rose(anyStrobe) |-> anyStrobe [*6] ##[1:2] !anyStrobe;
  endproperty
  a_strobe_length: assert property (p_strobe_length)
    else $error("strobe not one local clock long");

  property p_write_stable;
    localWriteStrobe |=> $stable(localWriteData) && $stable(localAddr);
  endproperty
  a_write_stable: assert property (p_write_stable)
    else $error("write data moved under strobe");

  property p_local_high_phase;
    $rose(localBusClock) |-> localBusClock [*3] ##[1:2] !localBusClock;
  endproperty
  a_local_high_phase: assert property (p_local_high_phase)
    else $error("local clock half period wrong");

  property p_fw_read;
    doRead && busAddr == OFS_FW_REVISION |=>
      busReadData == {16'h0000, FW_MAJOR, FW_MINOR};
  endproperty
  a_fw_read: assert property (p_fw_read)
    else $error("revision readback wrong");

  c_user_read: cover property (rdStrobe_reg ##[1:20] busAck);
  c_user_write: cover property (wrStrobe_reg ##[1:20] busAck);
  c_module_reset: cover property (moduleResetHit);
  c_iack: cover property (iackCycle && !busBusy);

endmodule

// >>> hdl/board_ctrl_pkg.sv
package board_ctrl_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register offsets from the board base address
  localparam logic [15:0] OFS_IRQ_VECTOR = 16'h8006;
  localparam logic [15:0] OFS_SLOT_POSITION = 16'h8008;
  localparam logic [15:0] OFS_MODULE_RESET = 16'h800a;
  localparam logic [15:0] OFS_FW_REVISION = 16'h800c;
  localparam logic [15:0] OFS_BRIDGE_FLASH_SEL = 16'h800e;
  localparam logic [15:0] OFS_BRIDGE_FLASH_DATA = 16'h8010;
  localparam logic [15:0] OFS_USER_FLASH_SEL = 16'h8012;
  localparam logic [15:0] OFS_USER_FLASH_DATA = 16'h8014;
  localparam logic [15:0] OFS_USER_CONFIG = 16'h8016;
  localparam logic [15:0] OFS_SCRATCH_SHORT = 16'h8018;
  localparam logic [15:0] OFS_SCRATCH_LONG = 16'h8020;
  // offsets below this limit belong to the user address space
  localparam logic [15:0] USER_SPACE_LIMIT = 16'h8000;

  ////////////////////////////////////////////////////////////////////////
  // field layouts and reset values
  localparam logic [7:0] IRQ_VECTOR_RESET = 8'hdd;
  localparam logic [4:0] SLOT_NO_GEO = 5'h1f;
  localparam int IMAGE_SELECT_BIT = 0;
  localparam int FLASH_BRIDGE = 0;
  localparam int FLASH_USER = 1;

  ////////////////////////////////////////////////////////////////////////
  // timing
  localparam int SYS_CLK_MHZ = 250;
  localparam int LOCAL_CLK_MHZ = 40;
  localparam int RESET_PULSE_NS = 200;
  localparam int RESET_PULSE_CYCLES =
    (RESET_PULSE_NS * SYS_CLK_MHZ + 999) / 1000;

  ////////////////////////////////////////////////////////////////////////
  // local register port sequencer
  typedef enum logic [1:0] {
    LS_IDLE = 2'b00,
    LS_WAIT = 2'b01,
    LS_STROBE = 2'b11,
    LS_FINISH = 2'b10
  } local_state_t;

endpackage

// >>> hdl/local_clock_gen.sv
`timescale 1ns/1ps

// fractional divider: toggles on accumulator wrap, average rate is exact
module local_clock_gen #(
  parameter int SYS_MHZ = 250,
  parameter int LOC_MHZ = 40
) (
  input wire logic sys_clk,
  input wire logic rst,
  output logic localClk,
  output logic toggleNow
);

  localparam logic [8:0] STEP = 9'(2 * LOC_MHZ);
  localparam logic [8:0] MODULUS = 9'(SYS_MHZ);

  logic [8:0] acc_reg;
  logic [8:0] acc_next;
  logic clk_reg;
  logic clk_next;
  logic [8:0] sum;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    sum = acc_reg + STEP;
    toggleNow = (sum >= MODULUS);
    acc_next = toggleNow ? (sum - MODULUS) : sum;
    clk_next = toggleNow ? ~clk_reg : clk_reg;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_reg <= 9'h000;
      clk_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      clk_reg <= clk_next;
    end
  end

  assign localClk = clk_reg;

endmodule

// >>> dv/user_logic_model.sv
`timescale 1ns/1ps

module user_logic_model (
  input wire logic localBusClock,
  input wire logic localBusReset_n,
  input wire logic localWriteStrobe,
  input wire logic localReadStrobe,
  input wire logic [15:0] localAddr,
  input wire logic [15:0] localWriteData,
  input wire logic userSpaceHit,
  output logic [15:0] localReadData
);
  logic [15:0] mem [16];
  logic [15:0] idle;

  always_ff @(posedge localBusClock or negedge localBusReset_n) begin
    if (!localBusReset_n) begin
      for (int i = 0; i < 16; i++) begin
        mem[i] <= 16'h0000;
      end
      idle <= 16'h0000;
    end else begin
      idle <= ~idle;
      if (localWriteStrobe && userSpaceHit) begin
        mem[localAddr[3:0]] <= localWriteData;
      end
    end
  end

  // datum only under a qualified read
  assign localReadData = (localReadStrobe && userSpaceHit) ?
    mem[localAddr[3:0]] : idle;
endmodule

// >>> dv/board_ctrl_regs_tb.sv
`timescale 1ns/1ps

module board_ctrl_regs_tb;
  import board_ctrl_pkg::*;
  typedef struct {bit doWr; logic [15:0] addr; logic [31:0] wdata;
    logic [31:0] expData;} row_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] busAddr = 16'h0000;
  logic [31:0] busWriteData = 32'h0000_0000;
  logic busWrite = 1'b0;
  logic busRead = 1'b0;
  logic iackCycle = 1'b0;
  logic [31:0] busReadData, rd;
  logic busAck, busBusy, userConfigReload, userImageStandard, hitSeen;
  logic [1:0][15:0] flashSelect;
  logic [15:0] flashWriteData, localAddr, localWriteData, localReadData;
  logic [1:0] flashWriteStrobe, flashReadStrobe;
  logic localBusClock, localBusReset_n, userSpaceHit;
  logic localWriteStrobe, localReadStrobe;
  logic [4:0] geoPins = 5'h0b;
  logic [31:0] noGeoData;
  logic [3:0] flashSeen = 4'h0;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  int n, c0, wrPulses;
  row_t rows [11] = '{
    '{0, OFS_IRQ_VECTOR, 32'h0, 32'hdd},
    '{1, OFS_IRQ_VECTOR, 32'hffff_ff5a, 32'h5a},
    '{1, OFS_FW_REVISION, 32'hffff, 32'h0102},
    '{1, OFS_SLOT_POSITION, 32'h1f, 32'h0b},
    '{1, OFS_SCRATCH_SHORT, 32'habcd_1234, 32'h1234},
    '{1, OFS_SCRATCH_LONG, 32'hdead_beef, 32'hdead_beef},
    '{1, OFS_BRIDGE_FLASH_SEL, 32'h3, 32'h3},
    '{1, OFS_USER_FLASH_SEL, 32'ha5, 32'ha5},
    '{1, OFS_BRIDGE_FLASH_DATA, 32'h11, 32'h8765},
    '{1, OFS_USER_FLASH_DATA, 32'h22, 32'h4321},
    '{1, 16'h8030, 32'h7, 32'h0}};

  board_ctrl_regs i_board_ctrl_regs (.sys_clk(sys_clk), .rst(rst),
    .busAddr(busAddr), .busWriteData(busWriteData), .busWrite(busWrite),
    .busRead(busRead), .iackCycle(iackCycle), .busReadData(busReadData),
    .busAck(busAck), .busBusy(busBusy), .geoPins(geoPins),
    .flashSelect(flashSelect), .flashWriteData(flashWriteData),
    .flashWriteStrobe(flashWriteStrobe), .flashReadStrobe(flashReadStrobe),
    .flashReadData({16'h4321, 16'h8765}),
    .userConfigReload(userConfigReload),
    .userImageStandard(userImageStandard), .localBusClock(localBusClock),
    .localBusReset_n(localBusReset_n), .localWriteStrobe(localWriteStrobe),
    .localReadStrobe(localReadStrobe), .localAddr(localAddr),
    .localWriteData(localWriteData), .localReadData(localReadData),
    .userSpaceHit(userSpaceHit));

  user_logic_model i_user_logic_model (.localBusClock(localBusClock),
    .localBusReset_n(localBusReset_n), .localWriteStrobe(localWriteStrobe),
    .localReadStrobe(localReadStrobe), .localAddr(localAddr),
    .localWriteData(localWriteData), .userSpaceHit(userSpaceHit),
    .localReadData(localReadData));

  // board variant without geographical pins, same bus
  board_ctrl_regs #(.HAS_GEO_PINS(1'b0)) i_board_ctrl_regs_no_geo (
    .sys_clk(sys_clk), .rst(rst), .busAddr(busAddr),
    .busWriteData(busWriteData), .busWrite(busWrite), .busRead(busRead),
    .iackCycle(iackCycle), .busReadData(noGeoData), .busAck(),
    .busBusy(), .geoPins(geoPins), .flashSelect(), .flashWriteData(),
    .flashWriteStrobe(), .flashReadStrobe(), .flashReadData(32'h0),
    .userConfigReload(), .userImageStandard(), .localBusClock(),
    .localBusReset_n(), .localWriteStrobe(), .localReadStrobe(),
    .localAddr(), .localWriteData(), .localReadData(16'h0000),
    .userSpaceHit());

  always #2 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    flashSeen <= flashSeen | {flashReadStrobe, flashWriteStrobe};
  end

  always @(posedge localBusClock) begin
    if (localWriteStrobe === 1'b1) begin
      wrPulses++;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // kind bits: 0 write, 1 read, 2 interrupt acknowledge
  task automatic bus_op(input logic [2:0] kind, input logic [15:0] a,
      input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    busWrite <= kind[0];
    busRead <= kind[1];
    iackCycle <= kind[2];
    busAddr <= a;
    busWriteData <= d;
    @(posedge sys_clk);
    busWrite <= 1'b0;
    busRead <= 1'b0;
    iackCycle <= 1'b0;
    #1;
    hitSeen = userSpaceHit;
    k = 0;
    while (busAck !== 1'b1 && k < 40) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    check({31'h0, busAck}, 32'h1);
    rd = busReadData;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    wrPulses = 0;
    repeat (5) @(posedge sys_clk);
    check({31'h0, localBusReset_n}, 32'h0);
    rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].doWr) begin
        bus_op(3'b001, rows[i].addr, rows[i].wdata);
      end
      bus_op(3'b010, rows[i].addr, 32'h0);
      check(rd, rows[i].expData);
    end
    check({31'h0, hitSeen}, 32'h0);
    check(flashSelect, 32'h00a5_0003);
    check({16'h0, flashWriteData}, 32'h22);
    check({28'h0, flashSeen}, 32'hf);
    @(posedge sys_clk);
    geoPins <= 5'h16;
    bus_op(3'b010, OFS_SLOT_POSITION, 32'h0);
    check(rd, 32'h16);
    check(noGeoData, 32'h1f);
    bus_op(3'b100, 16'h0000, 32'h0);
    check({24'h0, rd[7:0]}, 32'h5a);
    bus_op(3'b001, OFS_USER_CONFIG, 32'h1);
    check({userConfigReload, userImageStandard}, 32'h3);
    bus_op(3'b001, OFS_USER_CONFIG, 32'h0);
    check({userConfigReload, userImageStandard}, 32'h2);
    bus_op(3'b001, 16'h0004, 32'h5555_beef);
    check({31'h0, hitSeen}, 32'h1);
    check(wrPulses, 32'h1);
    bus_op(3'b010, 16'h0004, 32'h0);
    check(rd, 32'hbeef);
    bus_op(3'b010, 16'h0005, 32'h0);
    check(rd, 32'h0);
    @(posedge localBusClock);
    #1;
    c0 = cyc;
    repeat (4) @(posedge localBusClock);
    #1;
    check(cyc - c0, 4 * SYS_CLK_MHZ / LOCAL_CLK_MHZ);
    bus_op(3'b001, OFS_MODULE_RESET, 32'h1234);
    n = 0;
    while (localBusReset_n === 1'b0 && n < 200) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check(n, RESET_PULSE_CYCLES);
    bus_op(3'b010, OFS_IRQ_VECTOR, 32'h0);
    check(rd, 32'hdd);
    close_out();
  end
endmodule
